// ---- logic/fmx_pkg.sv ----
// fmx_pkg: constants shared by the file-move / pointer-load executor
// assumes nothing beyond a SystemVerilog tool
`default_nettype none
package fmx_pkg;
	localparam logic [7:0]  OP_OR_FILE      = 8'h10;  // 0001 00xx
	localparam logic [7:0]  OP_MOVE_FILE    = 8'h50;  // 0101 00xx
	localparam logic [7:0]  OP_LOAD_PTR     = 8'hEE;  // 1110 1110
	localparam logic [1:0]  LOAD_PTR_SUB    = 2'h0;   // bits 7:6 of first word
	localparam logic [3:0]  OP_F2F_FIRST    = 4'hC;
	localparam logic [3:0]  OP_SECOND_WORD  = 4'hF;
	localparam int          DEST_BIT        = 9;
	localparam int          ACCESS_BIT      = 8;
	localparam logic [7:0]  INDEXED_MAX     = 8'h5F;
	localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
	localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;
	localparam logic [11:0] ACCUM_ADDR      = 12'hFE8;
	localparam logic [1:0]  NUM_POINTERS    = 2'h3;
	localparam logic [3:0]  QUARTER_Q4      = 4'h8;
	localparam logic [3:0]  QUARTER_Q2      = 4'h2;
	localparam logic [3:0]  QUARTER_Q1      = 4'h1;
endpackage
`default_nettype wire

// ---- logic/fmx_mem_if.sv ----
// fmx_mem_if: data-memory port bundle between the executor and its address unit
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface fmx_mem_if;
	logic        access_bit;
	logic        ext_set;
	logic [7:0]  file_field;
	logic [3:0]  bank_sel;
	logic [7:0]  index_base;
	logic [11:0] addr;
	modport exec (output access_bit, output ext_set, output file_field, output bank_sel,
		output index_base, input addr);
	modport agu  (input access_bit, input ext_set, input file_field, input bank_sel,
		input index_base, output addr);
endinterface
`default_nettype wire

// ---- logic/fmx_addr_unit.sv ----
// fmx_addr_unit: forms the 12-bit data address of a single-word file instruction
// assumes combinational use inside the executor
`timescale 1ns/1ps
`default_nettype none
module fmx_addr_unit
	import fmx_pkg::*;
(
	fmx_mem_if.agu m
);
	always_comb begin
		if (m.access_bit) begin
			m.addr = {m.bank_sel, m.file_field};
		end else if (m.ext_set && m.file_field <= INDEXED_MAX) begin
			m.addr = {4'h0, 8'(m.index_base + m.file_field)};
		end else if (m.file_field >= ACCESS_SPLIT) begin
			m.addr = {ACCESS_HI_BANK, m.file_field};
		end else begin
			m.addr = {4'h0, m.file_field};
		end
	end
endmodule
`default_nettype wire

// ---- logic/fmx_exec.sv ----
// fmx_exec: executes OR-with-file, move-file, file-to-file move and pointer load
// assumes quarter strobe q_i one-hot (Q1..Q4), data memory read returns in same cycle
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - 0001 00da ORs accumulator with file register, result to destination
// - destination bit zero writes accumulator, one writes back to file
// - access bit clear uses access bank, set uses bank select register
// - access clear, extended set, field up to 95: indexed literal offset
// - 8-bit file field reaches any byte of the selected bank
// - 0101 00da copies file register unchanged to destination, one cycle
// - pointer load first word 1110 1110 00ff, low nibble literal top bits
// - pointer load writes 12-bit literal, low byte from second word
// - file-to-file first word 1100 plus 12-bit source, read first cycle
// - second word 1111 plus destination, written in Q4 of cycle two
// - file-to-file addresses whole 4096-byte space, bank register unused
// - accumulator location allowed as file-to-file source or destination
module fmx_exec
	import fmx_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  q_i,
	input  wire logic        instr_valid_i,
	input  wire logic [15:0] instr_i,
	input  wire logic        ext_set_i,
	input  wire logic [3:0]  bank_sel_i,
	input  wire logic [7:0]  index_base_i,
	input  wire logic [7:0]  mem_rdata_i,
	output var  logic [11:0] mem_addr_o,
	output var  logic        mem_rd_o,
	output var  logic        mem_wr_o,
	output var  logic [7:0]  mem_wdata_o,
	output var  logic [7:0]  accum_o,
	output var  logic        flag_n_o,
	output var  logic        flag_z_o,
	output var  logic [1:0]  ptr_wr_sel_o,
	output var  logic        ptr_wr_hi_o,
	output var  logic        ptr_wr_lo_o,
	output var  logic [7:0]  ptr_wdata_o,
	output var  logic        busy_o
);

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_F2F  = 3'b010,
		ST_LDP  = 3'b100
	} fmx_state_t;

	typedef struct packed {
		fmx_state_t  st;
		logic [7:0]  accum;
		logic        flag_n;
		logic        flag_z;
		logic [7:0]  hold;
		logic [1:0]  ptr_sel;
		logic [11:0] mem_addr;
		logic        mem_rd;
		logic        mem_wr;
		logic [7:0]  mem_wdata;
		logic [1:0]  ptr_wr_sel;
		logic        ptr_wr_hi;
		logic        ptr_wr_lo;
		logic [7:0]  ptr_wdata;
		logic        busy;
	} fmx_regs_t;

	fmx_regs_t r;
	fmx_regs_t next_r;

	fmx_mem_if mif ();
	logic [11:0] file_addr;

	assign mif.access_bit = instr_i[ACCESS_BIT];
	assign mif.ext_set    = ext_set_i;
	assign mif.file_field = instr_i[7:0];
	assign mif.bank_sel   = bank_sel_i;
	assign mif.index_base = index_base_i;
	assign file_addr      = mif.addr;

	fmx_addr_unit u_addr (
		.m (mif.agu)
	);

	function automatic logic is_byte_op(input logic [15:0] w, input logic [7:0] op);
		return w[15:10] == op[7:2];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic [7:0] result;
	logic       new_word;

	always_comb begin
		next_r           = r;
		next_r.mem_rd    = 1'b0;
		next_r.mem_wr    = 1'b0;
		next_r.ptr_wr_hi = 1'b0;
		next_r.ptr_wr_lo = 1'b0;
		result           = 8'h00;
		new_word         = instr_valid_i && q_i == QUARTER_Q1;
		unique case (r.st)
			ST_IDLE: begin
				if (new_word) begin
					if (is_byte_op(instr_i, OP_OR_FILE) || is_byte_op(instr_i, OP_MOVE_FILE)) begin
						next_r.mem_addr = file_addr;
						next_r.mem_rd   = 1'b1;
					end else if (instr_i[15:12] == OP_F2F_FIRST) begin
						next_r.mem_addr = instr_i[11:0];
						next_r.mem_rd   = 1'b1;
						next_r.st       = ST_F2F;
					end else if (instr_i[15:8] == OP_LOAD_PTR && instr_i[7:6] == LOAD_PTR_SUB
						&& instr_i[5:4] < NUM_POINTERS) begin
						next_r.ptr_sel  = instr_i[5:4];
						next_r.hold     = {4'h0, instr_i[3:0]};
						next_r.st       = ST_LDP;
					end
					// lone 1111 word and all other opcodes fall through idle
				end
				if (q_i == QUARTER_Q2 && r.mem_rd) begin
					next_r.hold = mem_rdata_i;
				end
				if (q_i == QUARTER_Q4 && instr_valid_i) begin
					if (is_byte_op(instr_i, OP_OR_FILE) || is_byte_op(instr_i, OP_MOVE_FILE)) begin
						result = is_byte_op(instr_i, OP_OR_FILE) ? (r.accum | r.hold) : r.hold;
						next_r.flag_n = result[7];
						next_r.flag_z = result == 8'h00;
						if (instr_i[DEST_BIT]) begin
							next_r.mem_wr    = 1'b1;
							next_r.mem_wdata = result;
						end else begin
							next_r.accum = result;
						end
					end
				end
			end
			ST_F2F: begin
				// accumulator lives here, not in data memory, so its location reads the register
				if (q_i == QUARTER_Q2 && r.mem_rd) begin
					next_r.hold = (r.mem_addr == ACCUM_ADDR) ? r.accum : mem_rdata_i;
				end
				// no read in second cycle: address changes only at write time
				if (q_i == QUARTER_Q4 && instr_valid_i && instr_i[15:12] == OP_SECOND_WORD
					&& !new_word) begin
					next_r.mem_addr  = instr_i[11:0];
					next_r.mem_wdata = r.hold;
					next_r.mem_wr    = 1'b1;
					if (instr_i[11:0] == ACCUM_ADDR) begin
						next_r.accum = r.hold;
					end
					next_r.st = ST_IDLE;
				end
			end
			ST_LDP: begin
				// first word still stands at its own Q4: high byte goes then
				if (q_i == QUARTER_Q4 && instr_valid_i && instr_i[15:8] == OP_LOAD_PTR) begin
					next_r.ptr_wr_sel = r.ptr_sel;
					next_r.ptr_wdata  = r.hold;
					next_r.ptr_wr_hi  = 1'b1;
				end else if (q_i == QUARTER_Q4 && instr_valid_i
					&& instr_i[15:12] == OP_SECOND_WORD) begin
					next_r.ptr_wr_sel = r.ptr_sel;
					next_r.ptr_wdata  = instr_i[7:0];
					next_r.ptr_wr_lo  = 1'b1;
					next_r.st         = ST_IDLE;
				end
			end
			default: begin
				next_r.st = ST_IDLE;
			end
		endcase
		// busy registered so the output comes straight from a flop
		next_r.busy = next_r.st != ST_IDLE;
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			r <= '{st: ST_IDLE, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign mem_addr_o   = r.mem_addr;
	assign mem_rd_o     = r.mem_rd;
	assign mem_wr_o     = r.mem_wr;
	assign mem_wdata_o  = r.mem_wdata;
	assign accum_o      = r.accum;
	assign flag_n_o     = r.flag_n;
	assign flag_z_o     = r.flag_z;
	assign ptr_wr_sel_o = r.ptr_wr_sel;
	assign ptr_wr_hi_o  = r.ptr_wr_hi;
	assign ptr_wr_lo_o  = r.ptr_wr_lo;
	assign ptr_wdata_o  = r.ptr_wdata;
	assign busy_o       = r.busy;

endmodule
`default_nettype wire

// ---- sim/fmx_mem_model.sv ----
// fmx_mem_model: data memory on the far side of the executor
// assumes a read is answered while the request pulse stands
`timescale 1ns/1ps
`default_nettype none
module fmx_mem_model (
	input  wire logic        clk_sys_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output var  logic [7:0]  rdata_o
);
	logic [7:0] mem [4096] = '{default: 8'h00};
	logic [7:0] last = 8'h00;
	// idle bus shows inverted data, so a late sample cannot pass
	assign rdata_o = rd_i ? mem[addr_i] : ~last;
	always @(posedge clk_sys_i) begin
		if (rd_i) last <= mem[addr_i];
		if (wr_i) mem[addr_i] <= wdata_i;
	end
endmodule
`default_nettype wire

// ---- sim/fmx_exec_chk.sv ----
// fmx_exec_chk: port assertions for fmx_exec
// assumes q_i one-hot, one instruction word per four edges
`timescale 1ns/1ps
`default_nettype none
module fmx_exec_chk
	import fmx_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	input wire logic [3:0]  q_i,
	input wire logic        instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [3:0]  bank_sel_i,
	input wire logic [11:0] mem_addr_o,
	input wire logic        mem_rd_o,
	input wire logic        mem_wr_o,
	input wire logic [7:0]  accum_o,
	input wire logic        flag_n_o,
	input wire logic        flag_z_o,
	input wire logic [1:0]  ptr_wr_sel_o,
	input wire logic        ptr_wr_hi_o,
	input wire logic        ptr_wr_lo_o,
	input wire logic [7:0]  ptr_wdata_o,
	input wire logic        busy_o
);
	logic [3:0]  kind;
	logic [15:0] w_q;
	logic [3:0]  b_q;
	// first word's top nibble kept in kind so a trailing 1111 word is told apart
	always_ff @(posedge clk_sys_i) begin
		w_q <= instr_i;
		b_q <= bank_sel_i;
		if (!rst_n_i) kind <= 4'h0;
		else if (q_i == QUARTER_Q1 && instr_valid_i && !busy_o) kind <= instr_i[15:12];
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_q1; q_i == QUARTER_Q1 && instr_valid_i && !busy_o; endsequence
	sequence s_q4; q_i == QUARTER_Q4 && instr_valid_i; endsequence
	or_read_a: assert property (s_q1 ##0 instr_i[15:10] == 6'h04 |=> mem_rd_o)
		else $error("no read after or decode");
	bank_addr_a: assert property (s_q1 ##0 instr_i[15:10] inside {6'h04, 6'h14} && instr_i[8]
		|=> mem_addr_o == {b_q, w_q[7:0]}) else $error("banked address wrong");
	f2f_src_a: assert property (s_q1 ##0 instr_i[15:12] == OP_F2F_FIRST
		|=> mem_rd_o && mem_addr_o == w_q[11:0]) else $error("move source wrong");
	f2f_dst_a: assert property (s_q4 ##0 busy_o && kind == OP_F2F_FIRST
		&& instr_i[15:12] == OP_SECOND_WORD
		|=> mem_wr_o && mem_addr_o == w_q[11:0]) else $error("move dest wrong");
	ptr_hi_a: assert property (s_q4 ##0 instr_i[15:6] == 10'h3B8 && instr_i[5:4] != 2'h3
		|=> ptr_wr_hi_o && ptr_wdata_o == {4'h0, w_q[3:0]} && ptr_wr_sel_o == w_q[5:4])
		else $error("pointer high write wrong");
	ptr_lo_a: assert property (s_q4 ##0 busy_o && kind == 4'hE
		&& instr_i[15:12] == OP_SECOND_WORD
		|=> ptr_wr_lo_o && ptr_wdata_o == w_q[7:0]) else $error("pointer low write wrong");
	nz_flags_a: assert property (s_q4 ##0 instr_i[15:10] inside {6'h04, 6'h14} && !instr_i[9]
		|=> flag_z_o == (accum_o == 8'h00) && flag_n_o == accum_o[7]) else $error("flags wrong");
	flags_kept_a: assert property (s_q4 ##0 busy_o |=> $stable({flag_n_o, flag_z_o}))
		else $error("flags changed");
	lone_nop_a: assert property (s_q1 ##0 instr_i[15:12] == OP_SECOND_WORD
		|=> (!mem_rd_o && !mem_wr_o && !ptr_wr_hi_o && !ptr_wr_lo_o) [*4])
		else $error("lone word acted");
endmodule
bind fmx_exec fmx_exec_chk chk (.*);
`default_nettype wire

// ---- sim/tb_top.sv ----
// tb_top: self-checking bench for fmx_exec
// assumes fmx_mem_model answers data reads
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_sys_i, rst_n_i, instr_valid_i, ext_set_i, mem_rd_o, mem_wr_o;
	logic        flag_n_o, flag_z_o, ptr_wr_hi_o, ptr_wr_lo_o, busy_o;
	logic [3:0]  q_i, bank_sel_i;
	logic [15:0] instr_i;
	logic [7:0]  index_base_i, mem_rdata_i, mem_wdata_o, accum_o, ptr_wdata_o;
	logic [11:0] mem_addr_o, last_rd;
	logic [1:0]  ptr_wr_sel_o;
	logic [9:0]  hi_seen, lo_seen;
	int          n_mismatch = 0;
	int          num_checks = 0;
	fmx_exec uut (.*);
	fmx_mem_model pm (.clk_sys_i(clk_sys_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (mem_rd_o) last_rd <= mem_addr_o;
		if (ptr_wr_hi_o) hi_seen <= {ptr_wr_sel_o, ptr_wdata_o};
		if (ptr_wr_lo_o) lo_seen <= {ptr_wr_sel_o, ptr_wdata_o};
	end
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task cyc(input logic [15:0] w, input logic v);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys_i);
			q_i <= 4'h1 << i;
			instr_i <= w;
			instr_valid_i <= v;
		end
	endtask
	// idle cycle lets the Q4 results land before checking
	task run1(input logic [15:0] w);
		cyc(w, 1'b1);
		cyc(16'h0000, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task t_idx;
		ext_set_i <= 1'b1;
		run1(16'h505F);
		chk(last_rd[7:0], 8'h7F);
		run1(16'h5060);
		chk(last_rd, 12'hF60);
		ext_set_i <= 1'b0;
	endtask
	task t_move;
		pm.mem[12'h340] = 8'h80;
		run1(16'h5140);
		chk({accum_o, flag_n_o, flag_z_o}, {8'h80, 2'b10});
		pm.mem[12'hFF5] = 8'h00;
		run1(16'h50F5);
		chk({accum_o, flag_n_o, flag_z_o}, {8'h00, 2'b01});
		run1(16'h5140);
	endtask
	task t_or;
		pm.mem[12'h341] = 8'h13;
		run1(16'h1141);
		chk({accum_o, flag_n_o}, {8'h93, 1'b1});
		pm.mem[12'h342] = 8'h04;
		run1(16'h1342);
		chk({pm.mem[12'h342], accum_o}, {8'h97, 8'h93});
	endtask
	// destinations avoid counter low and stack top bytes
	task t_f2f;
		pm.mem[12'h123] = 8'h5A;
		cyc(16'hC123, 1'b1);
		run1(16'hFABC);
		chk(pm.mem[12'hABC], 8'h5A);
		// memory copy differs, so only the accumulator itself can give 93
		pm.mem[12'hFE8] = 8'h00;
		cyc(16'hCFE8, 1'b1);
		run1(16'hF456);
		chk({pm.mem[12'h456], accum_o, flag_n_o}, {8'h93, 8'h93, 1'b1});
		cyc(16'hC123, 1'b1);
		run1(16'hFFE8);
		chk({accum_o, flag_n_o}, {8'h5A, 1'b1});
	endtask
	task t_ptr;
		for (int p = 0; p < 3; p++) begin
			cyc(16'hEE00 | 16'(p << 4) | 16'(p + 1), 1'b1);
			run1(16'hF0A0 | 16'(p));
			chk(hi_seen, {2'(p), 8'(p + 1)});
			chk(lo_seen, {2'(p), 8'(8'hA0 + p)});
		end
	endtask
	task t_lone;
		run1(16'hF123);
		chk({pm.mem[12'h123], accum_o}, {8'h5A, 8'h5A});
	endtask
	////////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		summarize;
	end
	initial begin
		rst_n_i = 1'b0;
		q_i = 4'h0;
		instr_i = 16'h0000;
		instr_valid_i = 1'b0;
		ext_set_i = 1'b0;
		bank_sel_i = 4'h3;
		index_base_i = 8'h20;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_idx;
		t_move;
		t_or;
		t_f2f;
		t_ptr;
		t_lone;
		summarize;
	end
endmodule
`default_nettype wire
